// File: shared/interval_timer_pkg.sv
package interval_timer_pkg;

  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  localparam int PRE_W = 8;
  localparam int DEC_W = 8;

  // Register byte offsets
  localparam logic [DEC_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [DEC_W-1:0] OFS_COUNT = 8'h04;

  // Control word field positions
  localparam int ON_BIT = 15;
  localparam int GATE_BIT = 6;
  localparam int PS_LSB = 4;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT = 1;

  // Prescale select codes and the matching terminal counts
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [PRE_W-1:0] TERM_DIV1 = 8'h00;
  localparam logic [PRE_W-1:0] TERM_DIV8 = 8'h07;
  localparam logic [PRE_W-1:0] TERM_DIV64 = 8'h3f;
  localparam logic [PRE_W-1:0] TERM_DIV256 = 8'hff;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic timer_on;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_sync_select;
    logic clock_source_select;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '0;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_GATED = 2'h1,
    MODE_SYNC = 2'h3,
    MODE_ASYNC = 2'h2
  } mode_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_READ = 2'h3,
    BUS_READ_DONE = 2'h2
  } bus_state_e;

  function automatic mode_e mode_of(input ctrl_s c);
    if (!c.clock_source_select) begin
      mode_of = c.gate_accumulate_enable ? MODE_GATED : MODE_TIMER;
    end else begin
      mode_of = c.external_sync_select ? MODE_SYNC : MODE_ASYNC;
    end
  endfunction

  function automatic logic [PRE_W-1:0] term_of(input logic [1:0] ps);
    case (ps)
      PS_DIV1: term_of = TERM_DIV1;
      PS_DIV8: term_of = TERM_DIV8;
      PS_DIV64: term_of = TERM_DIV64;
      default: term_of = TERM_DIV256;
    endcase
  endfunction

endpackage

// File: core/interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
module interval_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Count or gate pin
  input wire logic external_count_input,
  // Timer state
  output logic [15:0] count_value
);

  interval_timer_pkg::bus_state_e bus_state, next_bus_state;
  logic [interval_timer_pkg::DEC_W-1:0] addr_q, next_addr_q;
  logic [31:0] next_hrdata;
  interval_timer_pkg::ctrl_s ctrl, next_ctrl;
  logic [15:0] next_count_value;
  logic [interval_timer_pkg::PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic pin_prev, sync_stage1, sync_stage2;
  interval_timer_pkg::mode_e mode;
  logic addr_take, wr_ctrl, wr_count, count_load, pin_rise, src_pulse, pre_tick, count_tick;

  // Bus access
  assign addr_take = hsel && htrans[interval_timer_pkg::HTRANS_ACTIVE_BIT] && hready;
  assign hreadyout = (bus_state != interval_timer_pkg::BUS_READ);
  assign hresp = interval_timer_pkg::HRESP_OKAY;
  assign wr_ctrl = (bus_state == interval_timer_pkg::BUS_WRITE)
    && (addr_q == interval_timer_pkg::OFS_CTRL);
  assign wr_count = (bus_state == interval_timer_pkg::BUS_WRITE)
    && (addr_q == interval_timer_pkg::OFS_COUNT);

  always_comb begin
    next_addr_q = addr_q;
    next_bus_state = interval_timer_pkg::BUS_IDLE;
    next_hrdata = hrdata;
    if (bus_state == interval_timer_pkg::BUS_READ) begin
      // One wait state lets the read data come straight from a flip-flop
      next_bus_state = interval_timer_pkg::BUS_READ_DONE;
      case (addr_q)
        interval_timer_pkg::OFS_CTRL: begin
          next_hrdata = '0;
          next_hrdata[interval_timer_pkg::ON_BIT] = ctrl.timer_on;
          next_hrdata[interval_timer_pkg::GATE_BIT] = ctrl.gate_accumulate_enable;
          next_hrdata[interval_timer_pkg::PS_LSB+:2] = ctrl.prescale_select;
          next_hrdata[interval_timer_pkg::SYNC_BIT] = ctrl.external_sync_select;
          next_hrdata[interval_timer_pkg::SRC_BIT] = ctrl.clock_source_select;
        end
        interval_timer_pkg::OFS_COUNT: begin
          next_hrdata = {16'h0000, count_value};
        end
        default: begin
          next_hrdata = '0;
        end
      endcase
    end else if (addr_take) begin
      next_addr_q = haddr[interval_timer_pkg::DEC_W-1:0];
      next_bus_state = hwrite ? interval_timer_pkg::BUS_WRITE : interval_timer_pkg::BUS_READ;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= interval_timer_pkg::BUS_IDLE;
      addr_q <= '0;
      hrdata <= '0;
    end else begin
      bus_state <= next_bus_state;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
    end
  end

  // Control word
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.timer_on = hwdata[interval_timer_pkg::ON_BIT];
      next_ctrl.gate_accumulate_enable = hwdata[interval_timer_pkg::GATE_BIT];
      next_ctrl.prescale_select = hwdata[interval_timer_pkg::PS_LSB+:2];
      next_ctrl.external_sync_select = hwdata[interval_timer_pkg::SYNC_BIT];
      next_ctrl.clock_source_select = hwdata[interval_timer_pkg::SRC_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= interval_timer_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Clock source, prescaler and optional synchroniser
  assign mode = interval_timer_pkg::mode_of(ctrl);
  assign pin_rise = external_count_input && !pin_prev;

  always_comb begin
    case (mode)
      interval_timer_pkg::MODE_TIMER: src_pulse = 1'b1;
      interval_timer_pkg::MODE_GATED: src_pulse = external_count_input;
      interval_timer_pkg::MODE_SYNC: src_pulse = pin_rise;
      interval_timer_pkg::MODE_ASYNC: src_pulse = pin_rise;
      default: src_pulse = 1'b0;
    endcase
    src_pulse = src_pulse && ctrl.timer_on;
  end

  assign pre_tick = src_pulse
    && (pre_cnt == interval_timer_pkg::term_of(ctrl.prescale_select));

  always_comb begin
    next_pre_cnt = pre_cnt;
    // A reconfigure or reload restarts the division so the first period is whole
    if (!ctrl.timer_on || wr_ctrl || count_load || pre_tick) begin
      next_pre_cnt = '0;
    end else if (src_pulse) begin
      next_pre_cnt = pre_cnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= '0;
      pin_prev <= 1'b0;
      sync_stage1 <= 1'b0;
      sync_stage2 <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      pin_prev <= external_count_input;
      // Timer ticks stay out of the retiming stages, so a switch to sync mode adds no count
      sync_stage1 <= pre_tick && (mode == interval_timer_pkg::MODE_SYNC);
      sync_stage2 <= sync_stage1;
    end
  end

  // Synchronised mode counts the retimed prescaler output, asynchronous mode counts it directly
  assign count_tick = (mode == interval_timer_pkg::MODE_SYNC)
    ? (sync_stage2 && ctrl.timer_on) : pre_tick;

  // Counter
  assign count_load = wr_count
    && !((mode == interval_timer_pkg::MODE_SYNC) && ctrl.timer_on);

  always_comb begin
    next_count_value = count_value;
    if (count_load) begin
      next_count_value = hwdata[interval_timer_pkg::COUNT_W-1:0];
    end else if (count_tick) begin
      next_count_value = count_value + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value <= interval_timer_pkg::COUNT_RESET;
    end else begin
      count_value <= next_count_value;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  count_hold_a: assert property (!ctrl.timer_on && !count_load |=> $stable(count_value))
    else $error("count moved while timer off");
  sync_write_block_a: assert property (
    wr_count && ctrl.timer_on && ctrl.clock_source_select && ctrl.external_sync_select
    |=> count_value != $past(hwdata[15:0]) || $past(count_value) == count_value
      || $past(count_tick))
    else $error("count write accepted in running sync mode");
  timer_step_a: assert property (
    mode == interval_timer_pkg::MODE_TIMER && ctrl.timer_on && ctrl.prescale_select == 2'h0
    && !count_load |=> count_value == $past(count_value) + 16'h0001)
    else $error("timer mode did not step every cycle");
  gate_hold_a: assert property (
    mode == interval_timer_pkg::MODE_GATED && !external_count_input && !count_load
    |=> $stable(count_value))
    else $error("gated count moved with gate low");
  async_edge_a: assert property (
    mode == interval_timer_pkg::MODE_ASYNC && ctrl.timer_on && ctrl.prescale_select == 2'h0
    && external_count_input && !pin_prev && !count_load
    |=> count_value == $past(count_value) + 16'h0001)
    else $error("async rising edge not counted at once");
  sync_delay_a: assert property (
    pre_tick && mode == interval_timer_pkg::MODE_SYNC ##1 !wr_ctrl
    |=> sync_stage2)
    else $error("synchronised tick not two cycles after prescaler");
  prescale_wrap_a: assert property (
    pre_tick && ctrl.prescale_select == 2'h1 |-> pre_cnt == 8'h07)
    else $error("1:8 prescaler fired at wrong count");
  control_bits_a: assert property (
    wr_ctrl |=> ctrl.clock_source_select == $past(hwdata[1])
      && ctrl.external_sync_select == $past(hwdata[2])
      && ctrl.gate_accumulate_enable == $past(hwdata[6]))
    else $error("control bits not taken from their positions");
  counter_wrap_a: assert property (
    count_value == 16'hffff && count_tick && !count_load |=> count_value == 16'h0000)
    else $error("16-bit counter did not wrap to zero");
  ext_source_a: assert property (
    ctrl.clock_source_select && ctrl.timer_on && !pin_rise
    |=> pre_cnt == $past(pre_cnt) || pre_cnt == 8'h00)
    else $error("counter mode prescaler ran without a pin edge");

  timer_wrap_c: cover property (mode == interval_timer_pkg::MODE_TIMER && count_tick
    && count_value == 16'hffff);
  gated_hold_c: cover property (mode == interval_timer_pkg::MODE_GATED && ctrl.timer_on
    && !external_count_input ##1 external_count_input);
  sync_block_c: cover property (wr_count && mode == interval_timer_pkg::MODE_SYNC
    && ctrl.timer_on);
  async_count_c: cover property (mode == interval_timer_pkg::MODE_ASYNC && count_tick);

endmodule
`default_nettype wire

// File: sim/count_source.sv
`timescale 1ns/1ns
`default_nettype none
module count_source (
  // Clock
  input wire logic hclk,
  // Commands from the bench
  input wire logic gate_high,
  input wire logic start,
  input wire logic [7:0] burst,
  input wire logic [3:0] gap,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [7:0] left = 8'h00;
  logic [3:0] wait_cnt = 4'h0;
  initial pin = 1'b0;
  assign busy = (left != 8'h00);
  // Pulses are high one cycle and low at least one, so every rise is seen
  always @(posedge hclk) begin
    if (start) begin
      left <= burst;
      wait_cnt <= 4'h0;
      pin <= 1'b0;
    end else if (left != 8'h00) begin
      if (pin) begin
        pin <= 1'b0;
        wait_cnt <= gap;
      end else if (wait_cnt > 4'h1) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else begin
        pin <= 1'b1;
        left <= left - 8'h01;
      end
    end else begin
      pin <= gate_high;
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin;
  logic busy;
  logic gate_high = 1'b0;
  logic start = 1'b0;
  logic [7:0] burst = 8'h00;
  logic [3:0] gap = 4'h1;
  logic [15:0] count_value;
  int failures = 0;
  int cmp_count = 0;
  always #4 hclk = ~hclk;
  interval_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_count_input(pin),
    .count_value(count_value));
  count_source u_src (.hclk(hclk), .gate_high(gate_high), .start(start), .burst(burst),
    .gap(gap), .pin(pin), .busy(busy));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Values are sampled at the falling edge, where they equal those at the next rise
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end while (!rdy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end while (!rdy);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rate(input string what, input int cycles, input logic [15:0] exp);
    logic [15:0] a;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    a = count_value;
    repeat (cycles) @(negedge hclk);
    check(what, {16'h0, exp}, {16'h0, count_value - a});
  endtask
  task automatic pulses(input logic [7:0] n, input logic [3:0] g);
    @(posedge hclk);
    burst <= n;
    gap <= g;
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
    do @(negedge hclk); while (busy);
    repeat (4) @(posedge hclk);
  endtask
  task automatic t_fields;
    rd("ctrl reset", 8'h00, 32'h0);
    rd("count reset", 8'h04, 32'h0);
    rd("unmapped", 8'h08, 32'h0);
    wr(8'h00, 32'hffff);
    rd("ctrl fields", 8'h00, 32'h8076);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1234);
    rd("count load", 8'h04, 32'h1234);
    rate("stopped", 20, 16'h0);
    $display("fields test done");
  endtask
  task automatic t_prescale;
    int div [4] = '{1, 8, 64, 256};
    // Starting just below the top makes the 1:1 run wrap in the settling cycles before its window
    wr(8'h04, 32'hfffe);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h8000 | (i << 4));
      rate("prescale", div[i] * 4, 16'h4);
      wr(8'h00, 32'h0);
    end
    $display("prescale test done");
  endtask
  task automatic t_gated;
    wr(8'h00, 32'h8044);
    rate("gate low", 10, 16'h0);
    @(posedge hclk);
    gate_high <= 1'b1;
    rate("gate high", 10, 16'ha);
    @(posedge hclk);
    gate_high <= 1'b0;
    wr(8'h00, 32'h0);
    $display("gated test done");
  endtask
  task automatic t_counters;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h8052);
    rate("no internal", 20, 16'h0);
    pulses(8'd16, 4'h3);
    rd("async count", 8'h04, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h8002);
    pulses(8'd3, 4'h2);
    rd("async direct", 8'h04, 32'h3);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h8006);
    pulses(8'd5, 4'h1);
    wr(8'h04, 32'h0abc);
    rd("sync count", 8'h04, 32'h5);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0abc);
    rd("load stopped", 8'h04, 32'h0abc);
    $display("counter test done");
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_fields;
    t_prescale;
    t_gated;
    t_counters;
    final_report;
  end
  // The tests take about 1650 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
